// ===== logic/chbeq_pkg.sv
package chbeq_pkg;

   // bus geometry
   localparam int unsigned CHBEQ_ADDR_W    = 16;
   localparam int unsigned CHBEQ_DATA_W    = 32;
   localparam int unsigned CHBEQ_STRB_W    = 4;

   // register indices as printed; byte address is four times the index
   localparam logic [15:0] CHBEQ_IDX_TAP3   = 16'h044c;
   localparam logic [15:0] CHBEQ_IDX_TAP4   = 16'h044e;
   localparam logic [15:0] CHBEQ_IDX_CENTRE = 16'h0450;
   localparam logic [15:0] CHBEQ_IDX_TAP6   = 16'h0453;
   localparam logic [15:0] CHBEQ_IDX_TAP7   = 16'h0455;

   localparam logic [15:0] CHBEQ_ADDR_TAP3   = {CHBEQ_IDX_TAP3[13:0], 2'b00};
   localparam logic [15:0] CHBEQ_ADDR_TAP4   = {CHBEQ_IDX_TAP4[13:0], 2'b00};
   localparam logic [15:0] CHBEQ_ADDR_CENTRE = {CHBEQ_IDX_CENTRE[13:0], 2'b00};
   localparam logic [15:0] CHBEQ_ADDR_TAP6   = {CHBEQ_IDX_TAP6[13:0], 2'b00};
   localparam logic [15:0] CHBEQ_ADDR_TAP7   = {CHBEQ_IDX_TAP7[13:0], 2'b00};

   // field layout
   localparam int unsigned CHBEQ_SIDE_REG_W = 16;
   localparam int unsigned CHBEQ_SIDE_COEF_LSB = 0;
   localparam int unsigned CHBEQ_SIDE_COEF_W = 12;
   localparam int unsigned CHBEQ_CTR_REG_W  = 24;
   localparam int unsigned CHBEQ_CTR_COEF_LSB = 0;
   localparam int unsigned CHBEQ_CTR_COEF_W = 18;
   localparam int unsigned CHBEQ_CTR_RSV_LSB = 18;
   localparam int unsigned CHBEQ_NUM_SIDE   = 4;

   // reset values
   localparam logic [15:0] CHBEQ_SIDE_RST   = 16'h0000;
   localparam logic [23:0] CHBEQ_CTR_RST    = 24'h000000;

   // response codes
   localparam logic [1:0]  CHBEQ_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  CHBEQ_RESP_SLVERR = 2'h2;

   // register select, one hot
   typedef enum logic [5:0] {
      CHBEQ_SEL_TAP3   = 6'h01,
      CHBEQ_SEL_TAP4   = 6'h02,
      CHBEQ_SEL_TAP6   = 6'h04,
      CHBEQ_SEL_TAP7   = 6'h08,
      CHBEQ_SEL_CENTRE = 6'h10,
      CHBEQ_SEL_NONE   = 6'h20
   } chbeq_sel_t;

   // coefficients presented to the filter datapath
   typedef struct packed {
      logic signed [11:0] tap3;
      logic signed [11:0] tap4;
      logic signed [17:0] centre;
      logic signed [11:0] tap6;
      logic signed [11:0] tap7;
   } chbeq_coef_t;

endpackage

// ===== logic/chbeq_coef_regs.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - side tap coefficients are signed twelve-bit values in bits 11:0
// - register at 0x44C gives channel two third tap in dual mode
// - register at 0x44E gives channel two fourth tap in dual mode
// - register at 0x450 gives eighteen-bit signed centre tap, bits 17:0
// - centre register bits 23:18 reserved, writable, reset zero
// - register at 0x453 gives channel two sixth tap in dual mode
// - register at 0x455 gives channel two seventh tap in dual mode
// - all coefficient and reserved fields reset to zero
// - channel two coefficients apply only in dual-channel mode
module chbeq_coef_regs
   import chbeq_pkg::*;
(
   // clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // write address channel
   input  wire logic [CHBEQ_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]              s_axi_awprot,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   // write data channel
   input  wire logic [CHBEQ_DATA_W-1:0] s_axi_wdata,
   input  wire logic [CHBEQ_STRB_W-1:0] s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   // write response channel
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // read address channel
   input  wire logic [CHBEQ_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]              s_axi_arprot,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   // read data channel
   output logic [CHBEQ_DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // mode and filter datapath
   input  wire logic                    dual_channel_mode,
   output chbeq_coef_t                  chb_coef,
   output logic                         chb_coef_active
);

////////////////////////////////////////////////////////////////////////////////

   // address decode, shared by read and write
   function automatic chbeq_sel_t decode_sel(input logic [CHBEQ_ADDR_W-1:0] a);
      chbeq_sel_t s;
      s = CHBEQ_SEL_NONE;
      if (a == CHBEQ_ADDR_TAP3) begin
         s = CHBEQ_SEL_TAP3;
      end else if (a == CHBEQ_ADDR_TAP4) begin
         s = CHBEQ_SEL_TAP4;
      end else if (a == CHBEQ_ADDR_CENTRE) begin
         s = CHBEQ_SEL_CENTRE;
      end else if (a == CHBEQ_ADDR_TAP6) begin
         s = CHBEQ_SEL_TAP6;
      end else if (a == CHBEQ_ADDR_TAP7) begin
         s = CHBEQ_SEL_TAP7;
      end
      return s;
   endfunction

   // byte-lane merge of a write into an old word
   function automatic logic [CHBEQ_DATA_W-1:0] merge_bytes(
      input logic [CHBEQ_DATA_W-1:0] old_w,
      input logic [CHBEQ_DATA_W-1:0] new_w,
      input logic [CHBEQ_STRB_W-1:0] strb
   );
      logic [CHBEQ_DATA_W-1:0] r;
      r = old_w;
      for (int b = 0; b < CHBEQ_STRB_W; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return r;
   endfunction

////////////////////////////////////////////////////////////////////////////////

   logic                    aw_held_ff;
   logic [CHBEQ_ADDR_W-1:0] aw_addr_ff;
   logic                    w_held_ff;
   logic [CHBEQ_DATA_W-1:0] w_data_ff;
   logic [CHBEQ_STRB_W-1:0] w_strb_ff;
   logic                    bvalid_ff;
   logic [1:0]              bresp_ff;
   logic                    rvalid_ff;
   logic [1:0]              rresp_ff;
   logic [CHBEQ_DATA_W-1:0] rdata_ff;

   logic [CHBEQ_SIDE_REG_W-1:0] side_ff [CHBEQ_NUM_SIDE];
   logic [CHBEQ_CTR_REG_W-1:0]  ctr_ff;
   chbeq_coef_t                 coef_ff;
   logic                        active_ff;

   logic                    do_wr;
   logic                    do_rd;
   chbeq_sel_t              wr_sel;
   chbeq_sel_t              rd_sel;
   logic [CHBEQ_DATA_W-1:0] nxt_rdata;

   // address and data are each held once taken, so either order works
   assign s_axi_awready = ~aw_held_ff;
   assign s_axi_wready  = ~w_held_ff;
   // one outstanding response at a time keeps ordering trivial
   assign do_wr         = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign wr_sel        = decode_sel(aw_addr_ff);

   assign s_axi_arready = ~rvalid_ff;
   assign do_rd         = s_axi_arvalid & ~rvalid_ff;
   assign rd_sel        = decode_sel(s_axi_araddr);

   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;

////////////////////////////////////////////////////////////////////////////////

   // write address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
      end else if (s_axi_awvalid && !aw_held_ff) begin
         aw_held_ff <= 1'b1;
         aw_addr_ff <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_held_ff <= 1'b0;
      end
   end

   // write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
      end else if (s_axi_wvalid && !w_held_ff) begin
         w_held_ff <= 1'b1;
         w_data_ff <= s_axi_wdata;
         w_strb_ff <= s_axi_wstrb;
      end else if (do_wr) begin
         w_held_ff <= 1'b0;
      end
   end

   // write response; unmapped addresses answer with an error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= CHBEQ_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (wr_sel == CHBEQ_SEL_NONE) ? CHBEQ_RESP_SLVERR : CHBEQ_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////

   // side tap storage; upper lanes of the bus word are dropped
   for (genvar i = 0; i < CHBEQ_NUM_SIDE; i++) begin : g_side
      logic [CHBEQ_DATA_W-1:0] merged;
      assign merged = merge_bytes({16'h0000, side_ff[i]}, w_data_ff, w_strb_ff);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            side_ff[i] <= CHBEQ_SIDE_RST;
         end else if (do_wr && wr_sel[i]) begin
            side_ff[i] <= merged[CHBEQ_SIDE_REG_W-1:0];
         end
      end
   end

   // centre tap storage, reserved bits kept as written
   logic [CHBEQ_DATA_W-1:0] ctr_merged;
   assign ctr_merged = merge_bytes({8'h00, ctr_ff}, w_data_ff, w_strb_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctr_ff <= CHBEQ_CTR_RST;
      end else if (do_wr && wr_sel == CHBEQ_SEL_CENTRE) begin
         ctr_ff <= ctr_merged[CHBEQ_CTR_REG_W-1:0];
      end
   end

////////////////////////////////////////////////////////////////////////////////

   // read mux; the full stored word comes back, reserved bits too
   always_comb begin
      nxt_rdata = '0;
      unique case (rd_sel)
         CHBEQ_SEL_TAP3: begin
            nxt_rdata = {16'h0000, side_ff[0]};
         end
         CHBEQ_SEL_TAP4: begin
            nxt_rdata = {16'h0000, side_ff[1]};
         end
         CHBEQ_SEL_TAP6: begin
            nxt_rdata = {16'h0000, side_ff[2]};
         end
         CHBEQ_SEL_TAP7: begin
            nxt_rdata = {16'h0000, side_ff[3]};
         end
         CHBEQ_SEL_CENTRE: begin
            nxt_rdata = {8'h00, ctr_ff};
         end
         CHBEQ_SEL_NONE: begin
            nxt_rdata = '0;
         end
      endcase
   end

   // read answer; a read never touches storage or the filter outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= CHBEQ_RESP_OKAY;
         rdata_ff  <= '0;
      end else if (do_rd) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= (rd_sel == CHBEQ_SEL_NONE) ? CHBEQ_RESP_SLVERR : CHBEQ_RESP_OKAY;
         rdata_ff  <= nxt_rdata;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////

   // filter view; zero outside dual mode so channel one taps rule alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         coef_ff   <= '0;
         active_ff <= 1'b0;
      end else if (dual_channel_mode) begin
         coef_ff.tap3   <= signed'(side_ff[0][CHBEQ_SIDE_COEF_LSB +: CHBEQ_SIDE_COEF_W]);
         coef_ff.tap4   <= signed'(side_ff[1][CHBEQ_SIDE_COEF_LSB +: CHBEQ_SIDE_COEF_W]);
         coef_ff.centre <= signed'(ctr_ff[CHBEQ_CTR_COEF_LSB +: CHBEQ_CTR_COEF_W]);
         coef_ff.tap6   <= signed'(side_ff[2][CHBEQ_SIDE_COEF_LSB +: CHBEQ_SIDE_COEF_W]);
         coef_ff.tap7   <= signed'(side_ff[3][CHBEQ_SIDE_COEF_LSB +: CHBEQ_SIDE_COEF_W]);
         active_ff      <= 1'b1;
      end else begin
         coef_ff   <= '0;
         active_ff <= 1'b0;
      end
   end

   assign chb_coef        = coef_ff;
   assign chb_coef_active = active_ff;

   // protection bits carry no meaning here
   logic prot_unused;
   assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

endmodule

// ===== testbench/chbeq_coef_regs_properties.sv
`timescale 1ns/1ps
module chbeq_coef_regs_properties
   import chbeq_pkg::*;
(
   // clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // register bus
   input wire logic [15:0]       s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic [15:0]       s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   // filter side
   input wire logic              dual_channel_mode,
   input wire chbeq_coef_t       chb_coef,
   input wire logic              chb_coef_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////
   function automatic logic mapped(logic [15:0] a);
      return a inside {CHBEQ_ADDR_TAP3, CHBEQ_ADDR_TAP4, CHBEQ_ADDR_CENTRE, CHBEQ_ADDR_TAP6, CHBEQ_ADDR_TAP7};
   endfunction
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   endsequence
   ////////////////////////////////////////////////////////////////
   // reset is checked while it is active, so no disable here
   property p_reset_zero;
      disable iff (1'b0) !aresetn |=> chb_coef == '0 && !chb_coef_active && !s_axi_bvalid && !s_axi_rvalid;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("outputs not cleared by reset");
   property p_single_zero;
      aresetn && !dual_channel_mode |=> chb_coef == '0 && !chb_coef_active;
   endproperty
   a_single_zero: assert property (p_single_zero) else $error("coefficients live in single mode");
   property p_dual_active;
      // sampled reset guard: the release edge itself still holds the outputs cleared
      aresetn && dual_channel_mode |=> chb_coef_active;
   endproperty
   a_dual_active: assert property (p_dual_active) else $error("coefficients inactive in dual mode");
   // a coefficient may only move after a completed write
   property p_no_disturb;
      $changed(chb_coef) && $past(dual_channel_mode) && $past(dual_channel_mode, 2) |-> $past(s_axi_bvalid);
   endproperty
   a_no_disturb: assert property (p_no_disturb) else $error("coefficient moved without write");
   property p_wr_resp;
      // pair held one cycle, response raised on the edge after
      s_wr_taken |-> ##2 s_axi_bvalid &&
         s_axi_bresp == (mapped($past(s_axi_awaddr, 2)) ? CHBEQ_RESP_OKAY : CHBEQ_RESP_SLVERR);
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response wrong");
   property p_unmapped_rd;
      s_ar_taken ##0 !mapped(s_axi_araddr) |=> s_axi_rvalid && s_axi_rresp == CHBEQ_RESP_SLVERR && s_axi_rdata == '0;
   endproperty
   a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read answered");
   property p_side_width;
      s_ar_taken ##0 (s_axi_araddr != CHBEQ_ADDR_CENTRE) |=> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_side_width: assert property (p_side_width) else $error("side tap read too wide");
   property p_read_ok;
      s_ar_taken ##0 mapped(s_axi_araddr) |=> s_axi_rvalid && s_axi_rresp == CHBEQ_RESP_OKAY && s_axi_rdata[31:24] == 8'h00;
   endproperty
   a_read_ok: assert property (p_read_ok) else $error("mapped read answered wrongly");
endmodule

bind chbeq_coef_regs chbeq_coef_regs_properties chk_u (
   .aclk              (aclk),
   .aresetn           (aresetn),
   .s_axi_awaddr      (s_axi_awaddr),
   .s_axi_awvalid     (s_axi_awvalid),
   .s_axi_awready     (s_axi_awready),
   .s_axi_wvalid      (s_axi_wvalid),
   .s_axi_wready      (s_axi_wready),
   .s_axi_bresp       (s_axi_bresp),
   .s_axi_bvalid      (s_axi_bvalid),
   .s_axi_araddr      (s_axi_araddr),
   .s_axi_arvalid     (s_axi_arvalid),
   .s_axi_arready     (s_axi_arready),
   .s_axi_rdata       (s_axi_rdata),
   .s_axi_rresp       (s_axi_rresp),
   .s_axi_rvalid      (s_axi_rvalid),
   .dual_channel_mode (dual_channel_mode),
   .chb_coef          (chb_coef),
   .chb_coef_active   (chb_coef_active)
);

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import chbeq_pkg::*;
;
   logic        aclk, aresetn, dual_channel_mode, chb_coef_active;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   chbeq_coef_t chb_coef;
   int          errors, compares;
   localparam logic [15:0] ADR [5] = '{CHBEQ_ADDR_TAP3, CHBEQ_ADDR_TAP4, CHBEQ_ADDR_CENTRE, CHBEQ_ADDR_TAP6, CHBEQ_ADDR_TAP7};
   localparam logic [31:0] WD [5] = '{32'hffff_f801, 32'h1234_5a7f, 32'hffe2_0001, 32'h0000_7ffe, 32'h0000_3123};
   localparam logic [31:0] RD [5] = '{32'h0000_f801, 32'h0000_5a7f, 32'h00e2_0001, 32'h0000_7ffe, 32'h0000_3123};
   localparam chbeq_coef_t EXP_COEF = '{tap3:12'h801, tap4:12'ha7f, centre:18'h20001, tap6:12'hffe, tap7:12'h123};

   chbeq_coef_regs dut_u (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .s_axi_awaddr      (s_axi_awaddr),
      .s_axi_awprot      (s_axi_awprot),
      .s_axi_awvalid     (s_axi_awvalid),
      .s_axi_awready     (s_axi_awready),
      .s_axi_wdata       (s_axi_wdata),
      .s_axi_wstrb       (s_axi_wstrb),
      .s_axi_wvalid      (s_axi_wvalid),
      .s_axi_wready      (s_axi_wready),
      .s_axi_bresp       (s_axi_bresp),
      .s_axi_bvalid      (s_axi_bvalid),
      .s_axi_bready      (s_axi_bready),
      .s_axi_araddr      (s_axi_araddr),
      .s_axi_arprot      (s_axi_arprot),
      .s_axi_arvalid     (s_axi_arvalid),
      .s_axi_arready     (s_axi_arready),
      .s_axi_rdata       (s_axi_rdata),
      .s_axi_rresp       (s_axi_rresp),
      .s_axi_rvalid      (s_axi_rvalid),
      .s_axi_rready      (s_axi_rready),
      .dual_channel_mode (dual_channel_mode),
      .chb_coef          (chb_coef),
      .chb_coef_active   (chb_coef_active)
   );

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // address and data go out together and are dropped as each is taken
   task automatic axi_wr(input logic [15:0] a, input logic [31:0] wd, input logic [3:0] s, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (s_axi_bvalid !== 1'b1) begin
         errors++;
         print_verdict();
      end
   endtask
   task automatic axi_rd(input logic [15:0] a, output logic [31:0] rd, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (s_axi_rvalid !== 1'b1) begin
         errors++;
         print_verdict();
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
      dual_channel_mode = 1'b1;
      errors = 0;
      compares = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         axi_rd(ADR[i], d, r);
         chk(66'(d), 66'h0);
      end
      chk(chb_coef, 66'h0);
      for (int i = 0; i < 5; i++) begin
         axi_wr(ADR[i], WD[i], 4'hf, r);
         chk(66'(r), 66'(CHBEQ_RESP_OKAY));
      end
      for (int i = 0; i < 5; i++) begin
         axi_rd(ADR[i], d, r);
         chk(66'(d), 66'(RD[i]));
      end
      // neighbours of the map must not alias onto a register
      axi_wr(16'h1134, 32'hffff_ffff, 4'hf, r);
      chk(66'(r), 66'(CHBEQ_RESP_SLVERR));
      axi_rd(16'h1131, d, r);
      chk(66'({r, d}), {32'h0, CHBEQ_RESP_SLVERR, 32'h0});
      chk(chb_coef, EXP_COEF);
      chk(66'(chb_coef.tap3), -66'sd2047);
      axi_wr(CHBEQ_ADDR_TAP4, 32'h0000_11ff, 4'h1, r);
      axi_rd(CHBEQ_ADDR_TAP4, d, r);
      chk(66'(d), 66'h5aff);
      dual_channel_mode <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(chb_coef, 66'h0);
      chk(66'(chb_coef_active), 66'h0);
      axi_rd(CHBEQ_ADDR_TAP3, d, r);
      chk(66'(d), 66'hf801);
      dual_channel_mode <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(66'(chb_coef_active), 66'h1);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(CHBEQ_ADDR_CENTRE, d, r);
      chk(66'(d), 66'h0);
      chk(chb_coef, 66'h0);
      print_verdict();
   end
endmodule
